// ### scfw_system_file.sv
`timescale 1ns/1ps
// Function
// - Byte file, length first, fields fixed
// - Identity fields readable, never writable
// - Writes need unprotected or password received
// - Watchdog measures idle stop to start
// - Upper bits reserved; code zero disables
// - Timeout is two-power multiplier times 30ms
// - Expiry releases the wired session
// - Identifier fixed prefix plus unique bytes
// - Low nibble wired, high nibble radio
module scfw_system_file
#(
	parameter int BASE_CYCLES = scfw_pkg::BASE_CYCLES,
	parameter logic [15:0] UID_PREFIX = 16'h5a5a, // Arbitrary value
	parameter logic [39:0] UID_SERIAL = 40'h0102030405, // Per-device bytes
	parameter logic [7:0] PART_CODE = 8'ha5 // Arbitrary value
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire scfw_pkg::scfw_req_type i_host_req,
	output scfw_pkg::scfw_rsp_type o_host_rsp,
	input wire scfw_pkg::scfw_req_type i_radio_req,
	output scfw_pkg::scfw_rsp_type o_radio_rsp,
	input wire logic i_password_ok,
	input wire logic i_session_open,
	input wire logic i_bus_start,
	input wire logic i_bus_stop,
	output logic o_session_release,
	output logic [3:0] o_host_pin_mode,
	output logic [3:0] o_radio_pin_mode,
	output logic o_answer_ready_mode,
	output logic o_radio_enabled
);
	import scfw_pkg::*;
	logic [7:0] protect_ff, nxt_protect;
	logic [7:0] wdog_ff, nxt_wdog;
	logic [7:0] pin_cfg_ff, nxt_pin_cfg;
	logic [7:0] rsvd_ff, nxt_rsvd;
	logic [7:0] radio_en_ff, nxt_radio_en;
	logic idle_ff, nxt_idle;
	scfw_rsp_type host_rsp_ff, nxt_host_rsp;
	scfw_rsp_type radio_rsp_ff, nxt_radio_rsp;
	logic [55:0] unique_identifier;
	logic granted;
	logic writable;
	logic write_ok;
	logic wdog_write;
	logic expire;

	// Identifier: fixed prefix then unique bytes
	assign unique_identifier = {UID_PREFIX, UID_SERIAL};
	assign granted = (protect_ff == PROTECT_OFF) || i_password_ok;

	// Read multiplexer for the whole file
	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFF_LEN_HI: v = FILE_LEN[15:8];
			OFF_LEN_LO: v = FILE_LEN[7:0];
			OFF_PROTECT: v = protect_ff;
			OFF_WDOG: v = wdog_ff;
			OFF_PIN_CFG: v = pin_cfg_ff;
			OFF_RSVD: v = rsvd_ff;
			OFF_RADIO_EN: v = radio_en_ff;
			OFF_MSG_CNT: v = MSG_CNT;
			OFF_MEM_HI: v = MEM_SIZE[15:8];
			OFF_MEM_LO: v = MEM_SIZE[7:0];
			OFF_PART: v = PART_CODE;
			default:
			begin
				// Identifier bytes, most significant first
				if (a >= OFF_UID && a < OFF_MEM_HI)
					v = unique_identifier[8'(8'd55 - 8'((a - OFF_UID) * 8)) -: 8];
				else
					v = 8'h00;
			end
		endcase
		return v;
	endfunction

	// Writable fields are the configuration bytes only
	assign writable = (i_host_req.addr >= OFF_PROTECT) && (i_host_req.addr <= OFF_RADIO_EN);
	assign write_ok = writable && granted;
	assign wdog_write = i_host_req.wr && write_ok && i_host_req.addr == OFF_WDOG;

	// Configuration bytes written from the wired side
	always_comb
	begin
		nxt_protect = protect_ff;
		nxt_wdog = wdog_ff;
		nxt_pin_cfg = pin_cfg_ff;
		nxt_rsvd = rsvd_ff;
		nxt_radio_en = radio_en_ff;
		if (i_host_req.wr && write_ok)
		begin
			case (i_host_req.addr)
				OFF_PROTECT: nxt_protect = i_host_req.wdata;
				OFF_WDOG: nxt_wdog = i_host_req.wdata;
				OFF_PIN_CFG: nxt_pin_cfg = i_host_req.wdata;
				OFF_RSVD: nxt_rsvd = i_host_req.wdata;
				OFF_RADIO_EN: nxt_radio_en = i_host_req.wdata;
				default: nxt_rsvd = rsvd_ff;
			endcase
		end
	end

	// Configuration registers, delivery state after reset
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			protect_ff <= RST_PROTECT;
			wdog_ff <= RST_WDOG;
			pin_cfg_ff <= RST_PIN_CFG;
			rsvd_ff <= RST_RSVD;
			radio_en_ff <= RST_RADIO_EN;
		end
		else
		begin
			protect_ff <= nxt_protect;
			wdog_ff <= nxt_wdog;
			pin_cfg_ff <= nxt_pin_cfg;
			rsvd_ff <= nxt_rsvd;
			radio_en_ff <= nxt_radio_en;
		end
	end

	// Answers to both sides, one cycle after the request
	always_comb
	begin
		nxt_host_rsp = '0;
		nxt_radio_rsp = '0;
		if (i_host_req.wr)
		begin
			nxt_host_rsp.valid = 1'b1;
			nxt_host_rsp.err = !write_ok;
		end
		else if (i_host_req.rd)
		begin
			nxt_host_rsp.valid = 1'b1;
			nxt_host_rsp.rdata = read_byte(i_host_req.addr);
		end
		// Radio side reads only; any write refused
		if (i_radio_req.wr)
		begin
			nxt_radio_rsp.valid = 1'b1;
			nxt_radio_rsp.err = 1'b1;
		end
		else if (i_radio_req.rd)
		begin
			nxt_radio_rsp.valid = 1'b1;
			nxt_radio_rsp.rdata = read_byte(i_radio_req.addr);
		end
	end

	// Answer registers, one-cycle pulses
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			host_rsp_ff <= '0;
			radio_rsp_ff <= '0;
		end
		else
		begin
			host_rsp_ff <= nxt_host_rsp;
			radio_rsp_ff <= nxt_radio_rsp;
		end
	end

	// Bus idle between stop and next start
	always_comb
	begin
		nxt_idle = idle_ff;
		if (i_bus_start || !i_session_open)
			nxt_idle = 1'b0;
		else if (i_bus_stop)
			nxt_idle = 1'b1;
	end

	// Bus idle flag register
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			idle_ff <= 1'b0;
		end
		else
		begin
			idle_ff <= nxt_idle;
		end
	end

	// Idle watchdog on the low three bits only
	scfw_idle_timer #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_timer (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_code(wdog_ff[WDOG_CODE_W-1:0]),
		.i_restart(i_bus_start || wdog_write),
		.i_idle(idle_ff && i_session_open),
		.o_expire(expire)
	);

	// Watchdog expiry releases the wired session
	assign o_session_release = expire;

	// Answers straight from their registers
	assign o_host_rsp = host_rsp_ff;
	assign o_radio_rsp = radio_rsp_ff;

	// Nibble split of the output pin byte
	assign o_host_pin_mode = pin_cfg_ff[3:0];
	assign o_radio_pin_mode = pin_cfg_ff[7:4];
	assign o_answer_ready_mode = pin_cfg_ff[3:0] == PIN_ANSWER_READY[3:0];

	// Radio front end follows bit zero
	assign o_radio_enabled = radio_en_ff[0];
endmodule // scfw_system_file

// ### scfw_pkg.sv
package scfw_pkg;
	// Byte offsets of the system file
	localparam logic [7:0] OFF_LEN_HI = 8'h00;
	localparam logic [7:0] OFF_LEN_LO = 8'h01;
	localparam logic [7:0] OFF_PROTECT = 8'h02;
	localparam logic [7:0] OFF_WDOG = 8'h03;
	localparam logic [7:0] OFF_PIN_CFG = 8'h04;
	localparam logic [7:0] OFF_RSVD = 8'h05;
	localparam logic [7:0] OFF_RADIO_EN = 8'h06;
	localparam logic [7:0] OFF_MSG_CNT = 8'h07;
	localparam logic [7:0] OFF_UID = 8'h08;
	localparam logic [7:0] OFF_MEM_HI = 8'h0f;
	localparam logic [7:0] OFF_MEM_LO = 8'h10;
	localparam logic [7:0] OFF_PART = 8'h11;
	// Values after reset and fixed contents
	localparam logic [15:0] FILE_LEN = 16'h0012;
	localparam logic [7:0] RST_PROTECT = 8'h01;
	localparam logic [7:0] RST_WDOG = 8'h00;
	localparam logic [7:0] RST_PIN_CFG = 8'h11;
	localparam logic [7:0] RST_RSVD = 8'h00;
	localparam logic [7:0] RST_RADIO_EN = 8'h01;
	localparam logic [7:0] MSG_CNT = 8'h00;
	localparam logic [15:0] MEM_SIZE = 16'h00ff;
	localparam logic [7:0] PROTECT_OFF = 8'h00;
	localparam logic [7:0] PIN_ANSWER_READY = 8'h03;
	// Field layout of the watchdog byte
	localparam int WDOG_CODE_W = 3;
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int WDOG_BASE_MS = 30;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int BASE_CYCLES = WDOG_BASE_MS * MS_CYCLES;
	// Byte access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scfw_req_type;
	typedef struct packed {
		logic valid;
		logic err;
		logic [7:0] rdata;
	} scfw_rsp_type;
endpackage

// ### scfw_idle_timer.sv
`timescale 1ns/1ps
module scfw_idle_timer
#(
	parameter int BASE_CYCLES = 6000000
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [2:0] i_code,
	input wire logic i_restart,
	input wire logic i_idle,
	output logic o_expire
);
	import scfw_pkg::*;
	logic [22:0] base_ff, nxt_base;
	logic [6:0] unit_ff, nxt_unit;
	logic [6:0] limit;
	logic nxt_expire;
	// Multiplier two to the power code minus one
	assign limit = 7'(7'h01 << (i_code - 3'h1));
	// Base tick counter and multiplier counter
	always_comb
	begin
		nxt_base = base_ff;
		nxt_unit = unit_ff;
		nxt_expire = 1'b0;
		if (i_restart || i_code == 3'h0 || !i_idle)
		begin
			nxt_base = '0;
			nxt_unit = '0;
		end
		else if (base_ff == 23'(BASE_CYCLES - 1))
		begin
			nxt_base = '0;
			if (unit_ff + 7'h01 == limit)
			begin
				nxt_expire = 1'b1;
				nxt_unit = '0;
			end
			else
				nxt_unit = unit_ff + 7'h01;
		end
		else
			nxt_base = base_ff + 23'h000001;
	end
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			base_ff <= '0;
			unit_ff <= '0;
			o_expire <= 1'b0;
		end
		else
		begin
			base_ff <= nxt_base;
			unit_ff <= nxt_unit;
			o_expire <= nxt_expire;
		end
	end
endmodule // scfw_idle_timer

// ### scfw_properties.sv
`timescale 1ns/1ps
module scfw_properties
import scfw_pkg::*;
#(
	parameter int BASE_CYCLES = 20
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire scfw_pkg::scfw_req_type i_host_req,
	input wire scfw_pkg::scfw_rsp_type o_host_rsp,
	input wire scfw_pkg::scfw_req_type i_radio_req,
	input wire scfw_pkg::scfw_rsp_type o_radio_rsp,
	input wire logic i_bus_start,
	input wire logic i_bus_stop,
	input wire logic i_password_ok,
	input wire logic i_session_open,
	input wire logic o_session_release,
	input wire logic [3:0] o_host_pin_mode,
	input wire logic [3:0] o_radio_pin_mode,
	input wire logic o_answer_ready_mode
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	logic [31:0] idle_ff, nxt_idle;
	wire hw = i_host_req.wr;
	wire pw = hw && i_host_req.addr == OFF_PIN_CFG;
	wire [7:0] pin = {o_radio_pin_mode, o_host_pin_mode};
	// Cycles since the last stop or start
	always_comb nxt_idle = (i_bus_stop | i_bus_start) ? '0 : idle_ff + {31'h0, ~&idle_ff};
	always_ff @(posedge i_core_clk) idle_ff <= i_rst_n ? nxt_idle : '0;
	chk_rsp_next: assert property (hw | i_host_req.rd |=> o_host_rsp.valid)
		else $error("host answer missing");
	chk_radio_wr_err: assert property (i_radio_req.wr |=> o_radio_rsp.err)
		else $error("radio write accepted");
	chk_radio_rd_ok: assert property (i_radio_req.rd && !i_radio_req.wr |=> !o_radio_rsp.err)
		else $error("radio read refused");
	chk_ro_refused: assert property (hw
		&& !(i_host_req.addr inside {[OFF_PROTECT:OFF_RADIO_EN]}) |=> o_host_rsp.err)
		else $error("read-only write accepted");
	chk_pw_write_ok: assert property (hw && i_password_ok
		&& i_host_req.addr inside {[OFF_PROTECT:OFF_RADIO_EN]} |=> !o_host_rsp.err)
		else $error("granted write refused");
	chk_start_restart: assert property (i_bus_start |=> !o_session_release)
		else $error("release right after start");
	chk_release_open: assert property (o_session_release |-> $past(i_session_open))
		else $error("release without open session");
	chk_pin_update: assert property (pw ##1 !o_host_rsp.err |-> pin == $past(i_host_req.wdata))
		else $error("pin config not stored");
	chk_pin_kept: assert property (pw ##1 o_host_rsp.err |-> $stable(pin))
		else $error("refused write changed pin config");
	chk_answer_mode: assert property (o_answer_ready_mode == (o_host_pin_mode == 4'h3))
		else $error("answer-ready mode wrong");
	chk_release_late: assert property (o_session_release |-> idle_ff >= BASE_CYCLES)
		else $error("release before timeout");
endmodule // scfw_properties
bind scfw_system_file scfw_properties #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.i_core_clk, .i_rst_n,
	.i_host_req, .o_host_rsp, .i_radio_req, .o_radio_rsp, .i_bus_start, .i_bus_stop,
	.o_session_release, .o_host_pin_mode, .o_radio_pin_mode, .o_answer_ready_mode,
	.i_password_ok, .i_session_open);

// ### scfw_bus_model.sv
`timescale 1ns/1ps
module scfw_bus_model
(
	input wire logic i_core_clk,
	output logic o_start,
	output logic o_stop,
	output logic o_open
);
	initial {o_start, o_stop, o_open} = 3'h0;
	// One start or stop pulse, session held open
	task automatic cond(input bit stop);
		@(posedge i_core_clk);
		o_open <= 1'h1;
		o_start <= !stop;
		o_stop <= stop;
		@(posedge i_core_clk);
		{o_start, o_stop} <= 2'h0;
	endtask
endmodule // scfw_bus_model

// ### scfw_system_file_tb_top.sv
`timescale 1ns/1ps
module scfw_system_file_tb_top;
import scfw_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, pw = 1'h0, st, sp, op, rel, ardy, ren;
	logic [3:0] hp, rp;
	scfw_req_type hq = '0, rq = '0;
	scfw_rsp_type hr, rr, r;
	int fails = 0, checks = 0, n;
	logic [7:0] t [19] = '{8'h00, 8'h12, 8'h01, 8'h00, 8'h11, 8'h00, 8'h01, 8'h00, 8'h5a,
		8'h5a, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00, 8'hff, 8'ha5, 8'h00};
	always #2.5 clk = ~clk;
	scfw_system_file #(.BASE_CYCLES(20), .UID_PREFIX(16'h5a5a), .UID_SERIAL(40'h0102030405),
		.PART_CODE(8'ha5)) DUT (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_host_req(hq), .o_host_rsp(hr), .i_radio_req(rq), .o_radio_rsp(rr),
		.i_password_ok(pw), .i_session_open(op), .i_bus_start(st), .i_bus_stop(sp),
		.o_session_release(rel), .o_host_pin_mode(hp), .o_radio_pin_mode(rp),
		.o_answer_ready_mode(ardy), .o_radio_enabled(ren));
	scfw_bus_model bus (.i_core_clk(clk), .o_start(st), .o_stop(sp), .o_open(op));
	task automatic c(input logic [7:0] g, e);
		checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: %h not %h", $time, g, e);
		end
	endtask
	// One byte access, answer judged the cycle after
	task automatic a(input bit s, w, input logic [7:0] ad, d, e, ed);
		@(posedge clk);
		if (s)
			rq <= '{!w, w, ad, d};
		else
			hq <= '{!w, w, ad, d};
		@(posedge clk);
		hq <= '0;
		rq <= '0;
		#1 r = s ? rr : hr;
		c({r.valid, 6'h0, r.err}, {7'h40, e[0]});
		if (!w)
			c(r.rdata, ed);
	endtask
	// Reset file seen from both sides; protected writes refused
	task automatic t_file();
		for (int i = 0; i < 19; i++)
		begin
			a(1'h0, 1'h1, 8'(i), 8'h3c, 8'h1, 8'h0);
			a(1'h0, 1'h0, 8'(i), 8'h0, 8'h0, t[i]);
			a(1'h1, 1'h0, 8'(i), 8'h0, 8'h0, t[i]);
		end
	endtask
	// Password grants writes; nibbles and answer-ready follow
	task automatic t_prot();
		@(posedge clk) pw <= 1'h1;
		a(1'h0, 1'h1, OFF_PIN_CFG, 8'h53, 8'h0, 8'h0);
		c({3'h0, ardy, hp}, 8'h13);
		c({4'h0, rp}, 8'h05);
		a(1'h0, 1'h1, OFF_PROTECT, PROTECT_OFF, 8'h0, 8'h0);
		@(posedge clk) pw <= 1'h0;
		a(1'h0, 1'h1, OFF_RSVD, 8'h7e, 8'h0, 8'h0);
		a(1'h1, 1'h1, OFF_RSVD, 8'h11, 8'h1, 8'h0);
		a(1'h0, 1'h0, OFF_RSVD, 8'h0, 8'h0, 8'h7e);
		c({7'h0, ren}, 8'h01);
		a(1'h0, 1'h1, OFF_RADIO_EN, 8'hfe, 8'h0, 8'h0);
		c({7'h0, ren}, 8'h00);
	endtask
	// Timeout per code, upper bits ignored, start restarts count
	task automatic t_wdog();
		logic [7:0] cd [4] = '{8'h00, 8'hf9, 8'h02, 8'h0b};
		for (int k = 0; k < 4; k++)
		begin
			a(1'h0, 1'h1, OFF_WDOG, cd[k], 8'h0, 8'h0);
			bus.cond(1'h1);
			repeat (5) @(posedge clk);
			bus.cond(1'h0);
			bus.cond(1'h1);
			// Sample the pulse between edges, clear of the launch
			for (n = 0; !rel && n < 300; n++)
				@(negedge clk);
			c(8'(k ? n >= (10 << k) && n <= (10 << k) + 4 : n == 300), 8'h1);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog on the whole run
	initial
	begin
		#100000;
		fails++;
		end_of_test();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		t_file();
		t_prot();
		t_wdog();
		end_of_test();
	end
endmodule // scfw_system_file_tb_top
